// ---- design/sgs_switcher.v ----
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "sgs_defs.vh"

module sgs_switcher #(
  parameter MS_CYCLES = `SGS_MS_CYCLES
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        gain_select_n,
  input  wire        position_done_flag,
  input  wire        position_near_flag,
  input  wire        ref_pulse_active,
  input  wire        ref_filter_busy,
  input  wire        position_control,
  input  wire        command_busy,
  input  wire        motor_stopped,
  output wire [15:0] speed_gain,
  output wire [15:0] speed_integral,
  output wire [15:0] position_gain,
  output wire [15:0] force_filter,
  output wire [15:0] follow_gain,
  output wire [15:0] follow_comp,
  output wire [15:0] friction_gain,
  output wire        speed_law_ip,
  output wire [1:0]  active_gain_monitor
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_RAMP = 2'd2;
  localparam [16:0] MIX_FULL = 17'h10000;
  localparam [31:0] MS_LAST  = MS_CYCLES - 1;

  // ==========================================================
  // helpers
  function [16:0] lerp;
    input [16:0] a;
    input [16:0] b;
    input [16:0] m;
    reg   [17:0] diff;
    reg   [35:0] prod;
    reg   [35:0] acc;
    begin
      diff = {1'b0, b} - {1'b0, a};
      prod = $signed(diff) * $signed({1'b0, m});
      acc  = {3'b000, a, 16'h0000} + prod;
      lerp = acc[32:16];
    end
  endfunction

  function [15:0] gmin;
    input [2:0] i;
    begin
      case (i)
        3'd0:    gmin = `SGS_G0_MIN;
        3'd1:    gmin = `SGS_G1_MIN;
        3'd2:    gmin = `SGS_G2_MIN;
        3'd3:    gmin = `SGS_G3_MIN;
        3'd4:    gmin = `SGS_G4_MIN;
        3'd5:    gmin = `SGS_G5_MIN;
        default: gmin = `SGS_G6_MIN;
      endcase
    end
  endfunction

  function [15:0] gmax;
    input [2:0] i;
    begin
      case (i)
        3'd0:    gmax = `SGS_G0_MAX;
        3'd1:    gmax = `SGS_G1_MAX;
        3'd2:    gmax = `SGS_G2_MAX;
        3'd3:    gmax = `SGS_G3_MAX;
        3'd4:    gmax = `SGS_G4_MAX;
        3'd5:    gmax = `SGS_G5_MAX;
        default: gmax = `SGS_G6_MAX;
      endcase
    end
  endfunction

  function [15:0] gdef;
    input [2:0] i;
    begin
      case (i)
        3'd0:    gdef = `SGS_G0_DEF;
        3'd1:    gdef = `SGS_G1_DEF;
        3'd2:    gdef = `SGS_G2_DEF;
        3'd3:    gdef = `SGS_G3_DEF;
        3'd4:    gdef = `SGS_G4_DEF;
        3'd5:    gdef = `SGS_G5_DEF;
        default: gdef = `SGS_G6_DEF;
      endcase
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0]  st;
    begin
      merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  wire [7:0] pin_raw = {gain_select_n, position_done_flag, position_near_flag,
                        ref_pulse_active, ref_filter_busy, position_control,
                        command_busy, motor_stopped};
  reg  [7:0] pin_meta;
  reg  [7:0] pin_s;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 8'h81;
      pin_s    <= 8'h81;
    end else begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
    end
  end
  wire sel_n    = pin_s[7];
  wire done_f   = pin_s[6];
  wire near_f   = pin_s[5];
  wire pulse_f  = pin_s[4];
  wire filt_f   = pin_s[3];
  wire pos_ctl  = pin_s[2];
  wire cmd_f    = pin_s[1];
  wire stop_f   = pin_s[0];

  // ==========================================================
  // register storage
  reg [8:0]  config_reg;
  reg [15:0] wait1;
  reg [15:0] wait2;
  reg [15:0] ramp1;
  reg [15:0] ramp2;
  reg [15:0] gain_a [0:`SGS_NGAIN-1];
  reg [15:0] gain_b [0:`SGS_NGAIN-1];

  wire [3:0] mode_dig = config_reg[`SGS_CFG_MODE_LSB +: 4];
  wire [3:0] cond_dig = config_reg[`SGS_CFG_COND_LSB +: 4];
  wire       auto_en  = (mode_dig == `SGS_MODE_AUTO);

  // ==========================================================
  // switching decision
  reg cond_a;
  reg fixed_set;
  always @* begin
    case (cond_dig)
      4'h1:    cond_a = !done_f;
      4'h2:    cond_a = near_f;
      4'h3:    cond_a = !near_f;
      4'h4:    cond_a = !filt_f && !pulse_f;
      4'h5:    cond_a = pulse_f;
      default: cond_a = done_f;
    endcase
    fixed_set = cond_dig[0];
  end

  // want: 0 = gain set 1, 1 = gain set 2
  wire auto_run = auto_en && pos_ctl;
  wire want = !auto_en ? !sel_n :
              (pos_ctl ? cond_a : fixed_set);

  // ==========================================================
  // wait and ramp engine
  reg [1:0]  state;
  reg        target;
  reg [16:0] mix;
  reg [16:0] mix_start;
  reg [15:0] k;
  reg [31:0] pre;
  reg        follow_set;

  wire        ms_tick  = (pre == MS_LAST);
  wire [15:0] k_inc    = k + 16'h0001;
  // delays read live so a rewrite takes effect at once
  wire [15:0] wait_len = want ? wait1 : wait2;
  wire [15:0] ramp_len = target ? ramp1 : ramp2;
  wire [16:0] mix_end  = target ? MIX_FULL : 17'h00000;
  wire [31:0] ratio_w  = (k_inc >= ramp_len || ramp_len == 16'h0000) ?
                         32'h00010000 : ({k_inc, 16'h0000} / {16'h0000, ramp_len});
  wire [16:0] mix_step = lerp(mix_start, mix_end, ratio_w[16:0]);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      target     <= 1'b0;
      mix        <= 17'h00000;
      mix_start  <= 17'h00000;
      k          <= 16'h0000;
      pre        <= 32'h00000000;
      follow_set <= 1'b0;
    end else begin
      pre <= (ms_tick || state == ST_IDLE) ? 32'h00000000 : pre + 32'h00000001;
      if (!auto_en && !cmd_f && stop_f) begin
        follow_set <= want;
      end
      case (state)
        ST_IDLE: begin
          if (!auto_run) begin
            target <= want;
            mix    <= want ? MIX_FULL : 17'h00000;
          end else if (want != target || mix != mix_end) begin
            state <= ST_WAIT;
            k     <= 16'h0000;
            pre   <= 32'h00000000;
          end
        end
        ST_WAIT: begin
          if (!auto_run) begin
            state <= ST_IDLE;
          end else if (wait_len == 16'h0000 ||
                       (ms_tick && k_inc >= wait_len)) begin
            state     <= ST_RAMP;
            target    <= want;
            mix_start <= mix;
            k         <= 16'h0000;
            pre       <= 32'h00000000;
          end else if (ms_tick) begin
            k <= k_inc;
          end
        end
        ST_RAMP: begin
          if (!auto_run) begin
            state <= ST_IDLE;
          end else if (want != target) begin
            // reversal mid-ramp waits afresh from where the mix stands
            state <= ST_WAIT;
            k     <= 16'h0000;
            pre   <= 32'h00000000;
          end else if (ramp_len == 16'h0000) begin
            mix   <= mix_end;
            state <= ST_IDLE;
          end else if (ms_tick) begin
            mix <= mix_step;
            k   <= k_inc;
            if (k_inc >= ramp_len) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // effective gain outputs
  reg [15:0] eff [0:`SGS_NGAIN-1];
  genvar gi;
  generate
    for (gi = 0; gi < `SGS_NGAIN; gi = gi + 1) begin : g_eff
      wire [16:0] blend = lerp({1'b0, gain_a[gi]}, {1'b0, gain_b[gi]}, mix);
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          eff[gi] <= gdef(gi);
        end else if (gi == 4 || gi == 5) begin
          eff[gi] <= follow_set ? gain_b[gi] : gain_a[gi];
        end else begin
          eff[gi] <= blend[15:0];
        end
      end
    end
  endgenerate

  assign speed_gain     = eff[0];
  assign speed_integral = eff[1];
  assign position_gain  = eff[2];
  assign force_filter   = eff[3];
  assign follow_gain    = eff[4];
  assign follow_comp    = eff[5];
  assign friction_gain  = eff[6];

  reg [1:0] monitor;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor <= 2'h1;
    end else begin
      monitor <= target ? 2'h2 : 2'h1;
    end
  end
  assign active_gain_monitor = monitor;
  // law bit only steers the loop; switching ignores it
  assign speed_law_ip = config_reg[`SGS_CFG_LAW_BIT];

  // ==========================================================
  // axi4-lite write channel
  reg        aw_held;
  reg [5:0]  aw_idx;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        bvalid;
  reg [1:0]  bresp;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;

  wire        do_write = aw_held && w_held && !bvalid;
  wire        is_ga    = (aw_idx[5:3] == 3'd1) && (aw_idx[2:0] != 3'd7);
  wire        is_gb    = (aw_idx[5:3] == 3'd2) && (aw_idx[2:0] != 3'd7);
  wire [2:0]  gsel     = aw_idx[2:0];
  wire [15:0] g_old    = is_ga ? gain_a[gsel] : gain_b[gsel];
  wire [15:0] g_new    = merge(g_old, w_data, w_strb);
  wire        g_ok     = (g_new >= gmin(gsel)) && (g_new <= gmax(gsel));
  wire        known    = (aw_idx <= `SGS_IDX_STATUS) || is_ga || is_gb;
  integer ri;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held    <= 1'b0;
      aw_idx     <= 6'h00;
      w_held     <= 1'b0;
      w_data     <= 32'h00000000;
      w_strb     <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= 2'h0;
      config_reg <= `SGS_CONFIG_RESET;
      wait1      <= `SGS_TIME_RESET;
      wait2      <= `SGS_TIME_RESET;
      ramp1      <= `SGS_TIME_RESET;
      ramp2      <= `SGS_TIME_RESET;
      for (ri = 0; ri < `SGS_NGAIN; ri = ri + 1) begin
        gain_a[ri] <= gdef(ri[2:0]);
        gain_b[ri] <= gdef(ri[2:0]);
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (bvalid && s_axi_bready) begin
        bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= known ? 2'h0 : 2'h3;
        case (aw_idx)
          `SGS_IDX_CONFIG: config_reg <= {w_strb[1] ? w_data[8] : config_reg[8],
                                          w_strb[0] ? w_data[7:0] : config_reg[7:0]};
          `SGS_IDX_WAIT1:  wait1 <= merge(wait1, w_data, w_strb);
          `SGS_IDX_WAIT2:  wait2 <= merge(wait2, w_data, w_strb);
          `SGS_IDX_RAMP1:  ramp1 <= merge(ramp1, w_data, w_strb);
          `SGS_IDX_RAMP2:  ramp2 <= merge(ramp2, w_data, w_strb);
          default: begin
            // out-of-range gain keeps the old value and answers slverr
            if ((is_ga || is_gb) && !g_ok) begin
              bresp <= 2'h2;
            end else if (is_ga) begin
              gain_a[gsel] <= g_new;
            end else if (is_gb) begin
              gain_b[gsel] <= g_new;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  reg        rvalid;
  reg [31:0] rdata;
  reg [1:0]  rresp;
  reg [31:0] rd_mux;
  reg        rd_ok;
  wire [5:0] ar_idx = s_axi_araddr[7:2];
  wire [2:0] ar_g   = ar_idx[2:0];

  always @* begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    case (ar_idx[5:3])
      3'd0: begin
        case (ar_idx[2:0])
          3'd0:    rd_mux = {23'h000000, config_reg};
          3'd1:    rd_mux = {16'h0000, wait1};
          3'd2:    rd_mux = {16'h0000, wait2};
          3'd3:    rd_mux = {16'h0000, ramp1};
          3'd4:    rd_mux = {16'h0000, ramp2};
          3'd5:    rd_mux = {26'h0, follow_set, state, target, monitor};
          default: rd_ok  = 1'b0;
        endcase
      end
      3'd1: begin
        rd_ok  = (ar_g != 3'd7);
        rd_mux = rd_ok ? {16'h0000, gain_a[ar_g]} : 32'h00000000;
      end
      3'd2: begin
        rd_ok  = (ar_g != 3'd7);
        rd_mux = rd_ok ? {16'h0000, gain_b[ar_g]} : 32'h00000000;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= 2'h0;
    end else if (s_axi_arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_ok ? 2'h0 : 2'h3;
    end else if (rvalid && s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // sgs_switcher

// ---- design/sgs_defs.vh ----
// Function
// - manual mode: select input picks set one/two
// - automatic switching only under position control
// - config low digit 2 selects automatic mode
// - condition A true: set 1 to 2
// - condition A false: set 2 to 1
// - codes 0/1: positioning done on/off
// - codes 2/3: positioning near on/off
// - codes 4/5: reference idle / pulses present
// - outside position control: fixed set per code
// - wait programmed delay before any automatic change
// - ramp gains linearly within switching time
// - works under both speed control laws
// - speed integral 15..51200, default 2000
// - position gain 10..20000, default 400
// - force filter 0..65535, default 100
// - follow gain 10..20000, default 500
// - follow compensation 500..2000, default 1000
// - friction gain 10..1000, default 100
// - delays/times 0..65535 ms, immediate effect
// - monitor shows effective set 1 or 2
// - follow gains switch manual, idle, stopped only
`ifndef SGS_DEFS_VH
`define SGS_DEFS_VH

// ==========================================================
// timing
`define SGS_CLK_HZ          50000000
`define SGS_TICK_MS         1
`define SGS_MS_CYCLES       (`SGS_CLK_HZ / 1000 * `SGS_TICK_MS)

// ==========================================================
// register word indices (byte address = index * 4)
`define SGS_IDX_CONFIG      6'h00
`define SGS_IDX_WAIT1       6'h01
`define SGS_IDX_WAIT2       6'h02
`define SGS_IDX_RAMP1       6'h03
`define SGS_IDX_RAMP2       6'h04
`define SGS_IDX_STATUS      6'h05
`define SGS_IDX_GAIN_A      6'h08
`define SGS_IDX_GAIN_B      6'h10

// ==========================================================
// config fields
`define SGS_CFG_MODE_LSB    0
`define SGS_CFG_COND_LSB    4
`define SGS_CFG_LAW_BIT     8
`define SGS_MODE_AUTO       4'h2
`define SGS_CONFIG_RESET    9'h000

// ==========================================================
// gain ranges and reset values, order: speed, integral,
// position, force filter, follow gain, follow comp, friction
`define SGS_NGAIN           7
`define SGS_G0_MIN 16'h000A
`define SGS_G0_MAX 16'h4E20
`define SGS_G0_DEF 16'h0190
`define SGS_G1_MIN 16'h000F
`define SGS_G1_MAX 16'hC800
`define SGS_G1_DEF 16'h07D0
`define SGS_G2_MIN 16'h000A
`define SGS_G2_MAX 16'h4E20
`define SGS_G2_DEF 16'h0190
`define SGS_G3_MIN 16'h0000
`define SGS_G3_MAX 16'hFFFF
`define SGS_G3_DEF 16'h0064
`define SGS_G4_MIN 16'h000A
`define SGS_G4_MAX 16'h4E20
`define SGS_G4_DEF 16'h01F4
`define SGS_G5_MIN 16'h01F4
`define SGS_G5_MAX 16'h07D0
`define SGS_G5_DEF 16'h03E8
`define SGS_G6_MIN 16'h000A
`define SGS_G6_MAX 16'h03E8
`define SGS_G6_DEF 16'h0064
`define SGS_TIME_RESET      16'h0000

`endif

// ---- verif/sgs_host_model.sv ----
`timescale 1ns/1ns
module sgs_host_model (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       want_set2,
  input  wire [3:0] cond,
  input  wire       in_pos,
  input  wire       busy,
  input  wire       stopped,
  output reg        gain_select_n,
  output reg        position_done_flag,
  output reg        position_near_flag,
  output reg        ref_pulse_active,
  output reg        ref_filter_busy,
  output reg        position_control,
  output reg        command_busy,
  output reg        motor_stopped
);
  // ==========================================================
  // pins launched from a register, like a real controller port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_select_n <= 1'b1;
      {position_done_flag, position_near_flag, ref_pulse_active, ref_filter_busy} <= 4'h0;
      {position_control, command_busy, motor_stopped} <= 3'h1;
    end else begin
      gain_select_n <= ~want_set2;
      {position_done_flag, position_near_flag, ref_pulse_active, ref_filter_busy} <= cond;
      {position_control, command_busy, motor_stopped} <= {in_pos, busy, stopped};
    end
  end
endmodule // sgs_host_model

// ---- verif/sgs_switcher_monitor.sv ----
`timescale 1ns/1ns
module sgs_monitor (
  input wire        clk,
  input wire        rst_n,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        command_busy,
  input wire [15:0] speed_integral,
  input wire [15:0] position_gain,
  input wire [15:0] follow_gain,
  input wire [15:0] follow_comp,
  input wire [15:0] friction_gain,
  input wire [1:0]  active_gain_monitor
);
  // ==========================================================
  // busy run length; seven cycles outlasts the pin synchroniser
  reg [2:0] busy_run;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      busy_run <= 3'h0;
    else if (!command_busy)
      busy_run <= 3'h0;
    else if (busy_run != 3'h7)
      busy_run <= busy_run + 3'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // properties
  property p_mon; active_gain_monitor == 2'h1 || active_gain_monitor == 2'h2; endproperty
  a_mon: assert property (p_mon) else $error("monitor value illegal");
  property p_rst;
    !$past(rst_n) |-> active_gain_monitor == 2'h1 && position_gain == 16'h0190
      && follow_gain == 16'h01F4;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_int; speed_integral >= 16'h000F && speed_integral <= 16'hC800; endproperty
  a_int: assert property (p_int) else $error("integral out of range");
  property p_pos; position_gain >= 16'h000A && position_gain <= 16'h4E20; endproperty
  a_pos: assert property (p_pos) else $error("position gain out of range");
  property p_fol; follow_gain >= 16'h000A && follow_gain <= 16'h4E20; endproperty
  a_fol: assert property (p_fol) else $error("follow gain out of range");
  property p_cmp; follow_comp >= 16'h01F4 && follow_comp <= 16'h07D0; endproperty
  a_cmp: assert property (p_cmp) else $error("follow comp out of range");
  property p_fri; friction_gain >= 16'h000A && friction_gain <= 16'h03E8; endproperty
  a_fri: assert property (p_fri) else $error("friction gain out of range");
  property p_hold; busy_run == 3'h7 |=> $stable(follow_gain) && $stable(follow_comp); endproperty
  a_hold: assert property (p_hold) else $error("follow gains moved while busy");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_blk: assert property (p_blk) else $error("write taken under response");
  property p_resp; s_axi_bvalid |-> s_axi_bresp != 2'h1; endproperty
  a_resp: assert property (p_resp) else $error("write response code illegal");
endmodule // sgs_monitor

bind sgs_switcher sgs_monitor u_mon (
  .clk, .rst_n, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .command_busy, .speed_integral,
  .position_gain, .follow_gain, .follow_comp, .friction_gain, .active_gain_monitor
);

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
  // ==========================================================
  // signals
  reg         clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, want_set2, in_pos, busy, stopped;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr, i, ga;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb, cond;
  reg  [15:0] l, h;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, active_gain_monitor;
  wire [31:0] s_axi_rdata;
  wire        gain_select_n, position_done_flag, position_near_flag, ref_pulse_active;
  wire        ref_filter_busy, position_control, command_busy, motor_stopped, speed_law_ip;
  wire [15:0] speed_gain, speed_integral, position_gain, force_filter;
  wire [15:0] follow_gain, follow_comp, friction_gain;
  integer     bad_count, checked, cyc, n;
  // tables run from gain 6 down to gain 0
  localparam [111:0] LO  = {16'h000A, 16'h01F4, 16'h000A, 16'h0000, 16'h000A, 16'h000F, 16'h000A};
  localparam [111:0] HI  = {16'h03E8, 16'h07D0, 16'h4E20, 16'hFFFF, 16'h4E20, 16'hC800, 16'h4E20};
  localparam [111:0] DEF = {16'h0064, 16'h03E8, 16'h01F4, 16'h0064, 16'h0190, 16'h07D0, 16'h0190};
  // pin patterns {done, near, pulse, filter} per code, code 0 lowest
  localparam [23:0] CT = 24'h200408;
  localparam [23:0] CF = 24'h014080;

  sgs_switcher #(.MS_CYCLES(4)) uut (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .gain_select_n, .position_done_flag, .position_near_flag, .ref_pulse_active,
    .ref_filter_busy, .position_control, .command_busy, .motor_stopped, .speed_gain,
    .speed_integral, .position_gain, .force_filter, .follow_gain, .follow_comp,
    .friction_gain, .speed_law_ip, .active_gain_monitor
  );
  sgs_host_model u_host (
    .clk, .rst_n, .want_set2, .cond, .in_pos, .busy, .stopped, .gain_select_n,
    .position_done_flag, .position_near_flag, .ref_pulse_active, .ref_filter_busy,
    .position_control, .command_busy, .motor_stopped
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // checking and closing
  task chk(input [63:0] s, input [63:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  end

  // ==========================================================
  // bus tasks: look at the negedge, act on the posedge after it
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    reg       pa, pw, hb, ta, tw;
    reg [1:0] r;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      hb = 1'b0;
      while (!hb) begin
        @(negedge clk);
        ta = pa && s_axi_awready;
        tw = pw && s_axi_wready;
        hb = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge clk);
        if (ta) begin
          s_axi_awvalid <= 1'b0;
          pa = 1'b0;
        end
        if (tw) begin
          s_axi_wvalid <= 1'b0;
          pw = 1'b0;
        end
      end
      s_axi_bready <= 1'b0;
      chk({62'h0, r}, {62'h0, er});
    end
  endtask

  task axr(input [7:0] a, input [31:0] ed, input [1:0] er);
    reg        pa, hr, ta;
    reg [33:0] r;
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      pa = 1'b1;
      hr = 1'b0;
      while (!hr) begin
        @(negedge clk);
        ta = pa && s_axi_arready;
        hr = s_axi_rvalid;
        r = {s_axi_rresp, s_axi_rdata};
        @(posedge clk);
        if (ta) begin
          s_axi_arvalid <= 1'b0;
          pa = 1'b0;
        end
      end
      s_axi_rready <= 1'b0;
      chk({30'h0, r}, {30'h0, er, ed});
    end
  endtask

  task ws(input integer k);
    begin
      repeat (k) @(posedge clk);
      @(negedge clk);
    end
  endtask

  // ==========================================================
  // tests
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'h3;
    {want_set2, in_pos, busy, stopped, cond} = 8'h10;
    {bad_count, checked, cyc} = 96'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    ws(1);
    chk({speed_gain, speed_integral, position_gain, force_filter}, 64'h0190_07D0_0190_0064);
    chk({follow_gain, follow_comp, friction_gain, 14'h0, active_gain_monitor},
        64'h01F4_03E8_0064_0001);
    axr(8'h00, 32'h0, 2'h0);
    axr(8'h04, 32'h0, 2'h0);
    axw(8'hFC, 32'h1, 2'h3);
    axr(8'hFC, 32'h0, 2'h3);
    for (i = 8'h00; i < 8'h07; i = i + 8'h01) begin
      l = LO[16*i +: 16];
      h = HI[16*i +: 16];
      ga = 8'h40 + (i << 2);
      if (h != 16'hFFFF) axw(ga, {16'h0, h + 16'h1}, 2'h2);
      if (l != 16'h0000) axw(ga, {16'h0, l - 16'h1}, 2'h2);
      axr(ga, {16'h0, DEF[16*i +: 16]}, 2'h0);
      axw(ga, {16'h0, l}, 2'h0);
      axw(ga, {16'h0, h}, 2'h0);
      axr(ga, {16'h0, h}, 2'h0);
    end
    // manual switching, follow gains gated by the busy pin
    @(posedge clk);
    want_set2 <= 1'b1;
    ws(8);
    chk({position_gain, follow_gain, 30'h0, active_gain_monitor}, 64'h4E20_4E20_0000_0002);
    @(posedge clk);
    busy <= 1'b1;
    ws(4);
    @(posedge clk);
    want_set2 <= 1'b0;
    ws(8);
    chk({position_gain, follow_gain, 30'h0, active_gain_monitor}, 64'h0190_4E20_0000_0001);
    @(posedge clk);
    {busy, stopped} <= 2'b00;
    ws(8);
    chk({48'h0, follow_gain}, 64'h4E20);
    @(posedge clk);
    stopped <= 1'b1;
    ws(8);
    chk({48'h0, follow_gain}, 64'h01F4);
    // automatic: 2 ms wait, 4 ms ramp toward set 2, I-P law
    axw(8'h04, 32'h2, 2'h0);
    axw(8'h0C, 32'h4, 2'h0);
    axw(8'h00, 32'h102, 2'h0);
    @(posedge clk);
    in_pos <= 1'b1;
    ws(8);
    chk({63'h0, speed_law_ip}, 64'h1);
    @(posedge clk);
    cond <= 4'h8;
    ws(6);
    chk({position_gain, 46'h0, active_gain_monitor}, 64'h0190_0000_0000_0001);
    n = 0;
    while (active_gain_monitor !== 2'h2 && n < 40) begin
      @(negedge clk);
      n = n + 1;
    end
    chk({63'h0, n < 12}, 64'h1);
    n = 0;
    while (position_gain !== 16'h4E20 && n < 40) begin
      @(negedge clk);
      n = n + 1;
      if (position_gain != 16'h0190 && position_gain != 16'h4E20)
        chk({48'h0, (position_gain - 16'h0190) % 16'h1324}, 64'h0);
    end
    chk({63'h0, n >= 12 && n <= 18}, 64'h1);
    @(posedge clk);
    cond <= 4'h0;
    ws(8);
    chk({position_gain, 46'h0, active_gain_monitor}, 64'h0190_0000_0000_0001);
    // every condition code, in and out of position control
    axw(8'h04, 32'h0, 2'h0);
    axw(8'h0C, 32'h0, 2'h0);
    for (i = 8'h00; i < 8'h06; i = i + 8'h01) begin
      @(posedge clk);
      cond <= CF[4*i +: 4];
      axw(8'h00, {24'h0, i[3:0], 4'h2}, 2'h0);
      ws(8);
      chk({62'h0, active_gain_monitor}, 64'h1);
      @(posedge clk);
      cond <= CT[4*i +: 4];
      ws(8);
      chk({62'h0, active_gain_monitor}, 64'h2);
      @(posedge clk);
      in_pos <= 1'b0;
      ws(8);
      chk({62'h0, active_gain_monitor}, {62'h0, i[0] ? 2'h2 : 2'h1});
      @(posedge clk);
      in_pos <= 1'b1;
    end
    give_verdict;
  end
endmodule // tb
